// ---- rtl/ssa_defs.svh ----
// constants for the safety state acknowledge block
// Contract
// - normal 0000001, emergency stop one 0000010
// - both safe stops share code 0000100
// - safe motions one-hot 0001000 to 1000000
// - distinct diagnostic message per safety state
// - display text per state, one for motions
// - slave axis feeds back on zone output
// - door unlocked in special mode only
// - zone special demand reaches every axis cleanly
// - stand-alone axis reports special mode to PLC
`ifndef SSA_DEFS_SVH
`define SSA_DEFS_SVH

`define SSA_CODE_NORMAL   7'h01
`define SSA_CODE_STOP1ES  7'h02
`define SSA_CODE_STOP     7'h04
`define SSA_CODE_MOTION1  7'h08
`define SSA_CODE_MOTION2  7'h10
`define SSA_CODE_MOTION3  7'h20
`define SSA_CODE_MOTION4  7'h40

`define SSA_DIAG_STOP1ES  16'ha014
`define SSA_DIAG_STOP1    16'ha015
`define SSA_DIAG_STOP2    16'ha016
`define SSA_DIAG_MOTION1  16'ha018
`define SSA_DIAG_MOTION2  16'ha019
`define SSA_DIAG_MOTION3  16'ha020
`define SSA_DIAG_MOTION4  16'ha021

`define SSA_CLK_PERIOD_NS 10
`define SSA_ZONE_GRACE_NS 1000
`define SSA_ZONE_GRACE_CYC (`SSA_ZONE_GRACE_NS / `SSA_CLK_PERIOD_NS)

`endif

// ---- rtl/ssa_pkg.sv ----
// types for the safety state acknowledge block
package ssa_pkg;
   typedef enum logic [2:0] {
      st_normal, st_stop1_emerg, st_stop1, st_stop2,
      st_motion1, st_motion2, st_motion3, st_motion4
   } ssa_state_type;

   typedef enum logic [1:0] {
      op_ready, op_enabled, op_running
   } ssa_op_type;

   typedef enum logic [2:0] {
      drive_ready_text, drive_enabled_text, drive_running_text,
      emergency_stop_one_text, stop_one_text, stop_two_text,
      safe_motion_text
   } ssa_disp_type;

   typedef enum logic [2:0] {
      fb_none, fb_to_master, fb_door, fb_standalone, fb_plc
   } ssa_fb_type;
endpackage : ssa_pkg

// ---- rtl/ssa_feedback.sv ----
// safe feedback outputs towards zone master, door and safety plc
`timescale 1ns/1ns
`default_nettype none
module ssa_feedback
   import ssa_pkg::*;
(
   // clock and reset
   input  wire logic          ref_clk_in,
   input  wire logic          resetn_in,
   // state and configuration
   input  wire ssa_state_type state_in,
   input  wire ssa_fb_type    fb_mode_in,
   // feedback pins
   output logic               zone_feedback_output_out,
   output logic               door_unlock_out,
   output logic               plc_special_out
);
   logic special;
   logic door_special;

   assign special = (state_in != st_normal);
   // emergency stop is no door-opening mode
   assign door_special = special && (state_in != st_stop1_emerg);

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         zone_feedback_output_out <= 1'b0;
      end else begin
         zone_feedback_output_out <= (fb_mode_in == fb_to_master) &&
                                     special;
      end
   end

   // locked at reset: a door must never open by default
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         door_unlock_out <= 1'b0;
      end else begin
         door_unlock_out <= (fb_mode_in == fb_door) &&
                            door_special;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         plc_special_out <= 1'b0;
      end else begin
         plc_special_out <= ((fb_mode_in == fb_standalone) ||
                             (fb_mode_in == fb_plc)) &&
                            special;
      end
   end
endmodule : ssa_feedback
`default_nettype wire

// ---- rtl/ssa_top.sv ----
// safety state acknowledge: code, message, display text, feedback
`timescale 1ns/1ns
`default_nettype none
`include "ssa_defs.svh"
module ssa_top
   import ssa_pkg::*;
(
   // clock and reset
   input  wire logic          ref_clk_in,
   input  wire logic          resetn_in,
   // state selection
   input  wire logic          select_valid_in,
   input  wire ssa_state_type select_state_in,
   // normal operation context
   input  wire ssa_op_type    op_mode_in,
   input  wire logic [15:0]   op_mode_diag_in,
   // feedback configuration and zone demand
   input  wire ssa_fb_type    fb_mode_in,
   input  wire logic          zone_special_req_in,
   input  wire logic          zone_error_clear_in,
   // acknowledgment
   output ssa_state_type      state_out,
   output logic [6:0]         state_code_out,
   output logic [15:0]        diag_code_out,
   output ssa_disp_type       display_text_out,
   // feedback pins
   output logic               zone_feedback_output_out,
   output logic               door_unlock_out,
   output logic               plc_special_out,
   output logic               zone_error_out
);
   localparam int GRACE_CYC = `SSA_ZONE_GRACE_CYC;

   ssa_state_type state_q;
   logic [6:0]    code_q;
   logic [15:0]   diag_q;
   ssa_disp_type  disp_q;
   logic [7:0]    grace_q;
   logic          zone_err_q;

   function automatic logic [6:0] code_of(input ssa_state_type s);
      logic [6:0] c;
      c = `SSA_CODE_NORMAL;
      unique case (s)
         st_normal:      c = `SSA_CODE_NORMAL;
         st_stop1_emerg: c = `SSA_CODE_STOP1ES;
         st_stop1:       c = `SSA_CODE_STOP;
         st_stop2:       c = `SSA_CODE_STOP;
         st_motion1:     c = `SSA_CODE_MOTION1;
         st_motion2:     c = `SSA_CODE_MOTION2;
         st_motion3:     c = `SSA_CODE_MOTION3;
         st_motion4:     c = `SSA_CODE_MOTION4;
      endcase
      return c;
   endfunction : code_of

   function automatic logic [15:0] diag_of(input ssa_state_type s,
                                           input logic [15:0] op_diag);
      logic [15:0] d;
      d = op_diag;
      unique case (s)
         st_normal:      d = op_diag;
         st_stop1_emerg: d = `SSA_DIAG_STOP1ES;
         st_stop1:       d = `SSA_DIAG_STOP1;
         st_stop2:       d = `SSA_DIAG_STOP2;
         st_motion1:     d = `SSA_DIAG_MOTION1;
         st_motion2:     d = `SSA_DIAG_MOTION2;
         st_motion3:     d = `SSA_DIAG_MOTION3;
         st_motion4:     d = `SSA_DIAG_MOTION4;
      endcase
      return d;
   endfunction : diag_of

   function automatic ssa_disp_type disp_of(input ssa_state_type s,
                                            input ssa_op_type op);
      ssa_disp_type t;
      t = drive_ready_text;
      unique case (s)
         st_normal: begin
            unique case (op)
               op_ready:   t = drive_ready_text;
               op_enabled: t = drive_enabled_text;
               op_running: t = drive_running_text;
               default:    t = drive_ready_text;
            endcase
         end
         st_stop1_emerg: t = emergency_stop_one_text;
         st_stop1:       t = stop_one_text;
         st_stop2:       t = stop_two_text;
         // motion number deliberately not visible on the display
         st_motion1, st_motion2,
         st_motion3, st_motion4: t = safe_motion_text;
      endcase
      return t;
   endfunction : disp_of

   // state and code load on the same edge so they never disagree
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= st_normal;
      end else if (select_valid_in) begin
         state_q <= select_state_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         code_q <= `SSA_CODE_NORMAL;
      end else if (select_valid_in) begin
         code_q <= code_of(select_state_in);
      end
   end

   // message and display also track operation mode changes
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         diag_q <= 16'h0000;
      end else begin
         diag_q <= diag_of(select_valid_in ? select_state_in : state_q,
                           op_mode_diag_in);
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         disp_q <= drive_ready_text;
      end else begin
         disp_q <= disp_of(select_valid_in ? select_state_in : state_q,
                           op_mode_in);
      end
   end

   // zone demand must be followed within the grace time
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         grace_q <= 8'h00;
      end else if (!zone_special_req_in || state_q != st_normal) begin
         grace_q <= 8'h00;
      end else if (grace_q != GRACE_CYC[7:0]) begin
         grace_q <= grace_q + 8'h01;
      end
   end

   // sticky: a new violation outranks the clear in the same cycle
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         zone_err_q <= 1'b0;
      end else if (grace_q == GRACE_CYC[7:0]) begin
         zone_err_q <= 1'b1;
      end else if (zone_error_clear_in) begin
         zone_err_q <= 1'b0;
      end
   end

   ssa_feedback u_feedback (
      .ref_clk_in               (ref_clk_in),
      .resetn_in                (resetn_in),
      .state_in                 (state_q),
      .fb_mode_in               (fb_mode_in),
      .zone_feedback_output_out (zone_feedback_output_out),
      .door_unlock_out          (door_unlock_out),
      .plc_special_out          (plc_special_out)
   );

   // both acknowledgment views are readable by the partner
   assign state_out        = state_q;
   assign state_code_out   = code_q;
   assign diag_code_out    = diag_q;
   assign display_text_out = disp_q;
   assign zone_error_out   = zone_err_q;

   // checks
   a_code_onehot: assert property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      $onehot(state_code_out))
      else $error("state code not one-hot");

   a_code_follows: assert property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      select_valid_in |=> state_code_out == code_of($past(select_state_in)))
      else $error("state code did not follow selection");

   a_normal_code: assert property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      (state_q == st_normal) == (state_code_out == 7'h01) &&
      (state_q == st_stop1_emerg) == (state_code_out == 7'h02))
      else $error("normal or emergency stop code wrong");

   a_stop_shared: assert property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      (state_q == st_stop1 || state_q == st_stop2)
      |-> state_code_out == 7'h04)
      else $error("safe stop code wrong");

   a_motion_code: assert property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      state_q == st_motion3 |-> state_code_out == 7'h20)
      else $error("motion three code wrong");

   a_diag_stop2: assert property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      select_valid_in && select_state_in == st_stop2
      |=> diag_code_out == 16'ha016)
      else $error("stop two message wrong");

   a_disp_motion: assert property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      select_valid_in && select_state_in >= st_motion1
      |=> display_text_out == safe_motion_text)
      else $error("motion display text wrong");

   a_door_locked: assert property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      state_q == st_normal |=> !door_unlock_out)
      else $error("door unlocked in normal operation");

   a_master_fb: assert property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      fb_mode_in == fb_to_master && state_q == st_motion1
      |=> zone_feedback_output_out)
      else $error("zone feedback missing");

   a_plc_fb: assert property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      fb_mode_in == fb_plc |=>
      plc_special_out == ($past(state_q) != st_normal))
      else $error("plc feedback wrong");

   a_zone_error: assert property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      grace_q == GRACE_CYC[7:0] |=> zone_error_out)
      else $error("zone error not raised");

   c_motion_sel: cover property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      select_valid_in && select_state_in == st_motion4);
   c_door_open: cover property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      door_unlock_out);
   c_zone_err: cover property (
      @(posedge ref_clk_in) disable iff (!resetn_in)
      $rose(zone_error_out));
endmodule : ssa_top
`default_nettype wire

// ---- dv/ssa_zone_partner.sv ----
// far-side model: zone master, door control or safety plc
`timescale 1ns/1ns
`default_nettype none
module ssa_zone_partner
   import ssa_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       resetn_in,
   // demand from the bench and configuration
   input  wire logic       demand_in,
   input  wire ssa_fb_type fb_mode_in,
   // feedback pins of the axis
   input  wire logic       zone_feedback_output_in,
   input  wire logic       door_unlock_in,
   input  wire logic       plc_special_in,
   // zone side
   output logic            zone_special_req_out,
   output logic            axis_special_out
);
   // demand leaves the far side on its own clock edge
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in)
         zone_special_req_out <= 1'b0;
      else
         zone_special_req_out <= demand_in;
   end
   // acknowledgment is read from whichever pin is wired for this axis
   always_comb begin
      case (fb_mode_in)
         fb_to_master: axis_special_out = zone_feedback_output_in;
         fb_door:      axis_special_out = door_unlock_in;
         default:      axis_special_out = plc_special_in;
      endcase
   end
endmodule : ssa_zone_partner
`default_nettype wire

// ---- dv/safety_state_acknowledge_bench.sv ----
// self-checking bench for the safety state acknowledge block
`timescale 1ns/1ns
`default_nettype none
module safety_state_acknowledge_bench
   import ssa_pkg::*;
;
   logic          ref_clk_in, resetn_in, select_valid_in, demand;
   ssa_state_type select_state_in, state_out, st;
   ssa_op_type    op_mode_in;
   logic [15:0]   op_mode_diag_in, diag_code_out;
   ssa_fb_type    fb_mode_in;
   logic          zone_special_req_in, zone_error_clear_in, zone_error_out;
   logic [6:0]    state_code_out;
   ssa_disp_type  display_text_out;
   logic          zone_fb, door_unlock_out, plc_special_out, axis_sp, sp;
   int            num_errors, comparisons;

   ssa_top dut_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .select_valid_in(select_valid_in), .select_state_in(select_state_in),
      .op_mode_in(op_mode_in), .op_mode_diag_in(op_mode_diag_in),
      .fb_mode_in(fb_mode_in), .zone_special_req_in(zone_special_req_in),
      .zone_error_clear_in(zone_error_clear_in), .state_out(state_out),
      .state_code_out(state_code_out), .diag_code_out(diag_code_out),
      .display_text_out(display_text_out),
      .zone_feedback_output_out(zone_fb),
      .door_unlock_out(door_unlock_out), .plc_special_out(plc_special_out),
      .zone_error_out(zone_error_out));
   ssa_zone_partner partner_u (.ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in), .demand_in(demand), .fb_mode_in(fb_mode_in),
      .zone_feedback_output_in(zone_fb), .door_unlock_in(door_unlock_out),
      .plc_special_in(plc_special_out),
      .zone_special_req_out(zone_special_req_in),
      .axis_special_out(axis_sp));

   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // valid may stay high for back-to-back selections
   task automatic sel(input ssa_state_type s, input int hold);
      @(posedge ref_clk_in);
      select_valid_in <= 1'b1;
      select_state_in <= s;
      @(posedge ref_clk_in);
      if (hold == 0)
         select_valid_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      #1;
   endtask : sel

   function automatic logic [6:0] exp_code(input ssa_state_type s);
      case (s)
         st_normal:          return 7'h01;
         st_stop1_emerg:     return 7'h02;
         st_stop1, st_stop2: return 7'h04;
         default:            return 7'h08 << (int'(s) - 4);
      endcase
   endfunction : exp_code

   function automatic logic [15:0] exp_diag(input ssa_state_type s);
      case (s)
         st_normal:      return op_mode_diag_in;
         st_stop1_emerg: return 16'ha014;
         st_stop1:       return 16'ha015;
         st_stop2:       return 16'ha016;
         st_motion1:     return 16'ha018;
         st_motion2:     return 16'ha019;
         st_motion3:     return 16'ha020;
         default:        return 16'ha021;
      endcase
   endfunction : exp_diag

   function automatic ssa_disp_type exp_disp(input ssa_state_type s);
      case (s)
         st_normal:      return op_mode_in == op_running ?
                                   drive_running_text :
                                op_mode_in == op_enabled ?
                                   drive_enabled_text : drive_ready_text;
         st_stop1_emerg: return emergency_stop_one_text;
         st_stop1:       return stop_one_text;
         st_stop2:       return stop_two_text;
         default:        return safe_motion_text;
      endcase
   endfunction : exp_disp

   initial begin
      #20000;
      num_errors++;
      give_verdict();
   end

   initial begin
      resetn_in = 1'b0;
      select_valid_in = 1'b0;
      select_state_in = st_normal;
      op_mode_in = op_ready;
      op_mode_diag_in = 16'h0000;
      fb_mode_in = fb_none;
      zone_error_clear_in = 1'b0;
      demand = 1'b0;
      repeat (3) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      #1;
      chk(16'(state_code_out), 16'h0001);
      chk(16'(display_text_out), 16'(drive_ready_text));
      for (int f = 0; f < 5; f++) begin
         @(posedge ref_clk_in);
         fb_mode_in <= ssa_fb_type'(f[2:0]);
         op_mode_in <= ssa_op_type'(f % 3);
         op_mode_diag_in <= 16'hc000 + 16'(f);
         for (int s = 0; s < 8; s++) begin
            st = ssa_state_type'(s[2:0]);
            sel(st, 0);
            sp = (st != st_normal);
            chk(16'(state_out), 16'(st));
            chk(16'(state_code_out), 16'(exp_code(st)));
            chk(diag_code_out, exp_diag(st));
            chk(16'(display_text_out), 16'(exp_disp(st)));
            chk(16'(zone_fb), 16'(sp && f == 1));
            chk(16'(door_unlock_out),
                16'(sp && f == 2 && st != st_stop1_emerg));
            chk(16'(plc_special_out), 16'(sp && f > 2));
            if (f > 0 && st != st_stop1_emerg)
               chk(16'(axis_sp), 16'(sp));
         end
      end
      sel(st_motion1, 1);
      sel(st_stop2, 0);
      chk(16'(state_code_out), 16'h0004);
      // zone demand answered in time leaves no error
      @(posedge ref_clk_in);
      fb_mode_in <= fb_plc;
      sel(st_normal, 0);
      @(posedge ref_clk_in);
      demand <= 1'b1;
      repeat (50) @(posedge ref_clk_in);
      sel(st_motion3, 0);
      repeat (120) @(posedge ref_clk_in);
      #1;
      chk(16'(zone_error_out), 16'h0000);
      chk(16'(axis_sp), 16'h0001);
      sel(st_normal, 0);
      repeat (110) @(posedge ref_clk_in);
      #1;
      chk(16'(zone_error_out), 16'h0001);
      @(posedge ref_clk_in);
      demand <= 1'b0;
      zone_error_clear_in <= 1'b1;
      // grace count still full here: the set outranks the clear
      @(posedge ref_clk_in);
      #1;
      chk(16'(zone_error_out), 16'h0001);
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk(16'(zone_error_out), 16'h0000);
      give_verdict();
   end
endmodule : safety_state_acknowledge_bench
`default_nettype wire
